//--- src/tlic_pkg.sv
// Purpose: Shared constants and types for the two-level interrupt controller.
// Assumes: 8-bit register data, 4-bit register index on a plain strobe port.
// Notes: Bit positions are indices into the 8-bit registers below.
package tlic_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int VEC_W = 21;
    localparam int INSTR_CLKS_DEF = 4;
    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_MAIN = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_SECOND = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_THIRD = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_RCTL = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_STAT = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CLR = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_EN = 4'h6;
    // interrupt_control_main fields
    localparam int B_HIGH_LEVEL_GLOBAL_ENABLE = 7;
    localparam int B_LOW_LEVEL_GLOBAL_ENABLE = 6;
    localparam int B_T0IE = 5;
    localparam int B_X0IE = 4;
    localparam int B_PCIE = 3;
    localparam int B_T0IF = 2;
    localparam int B_X0IF = 1;
    localparam int B_PCIF = 0;
    // interrupt_control_second fields
    localparam int B_PUD = 7;
    localparam int B_EDG0 = 6;
    localparam int B_EDG1 = 5;
    localparam int B_EDG2 = 4;
    localparam int B_T0IP = 2;
    localparam int B_PCIP = 0;
    // Third control register fields
    localparam int B_X2IP = 7;
    localparam int B_X1IP = 6;
    localparam int B_PRIP = 5;
    localparam int B_X2IE = 4;
    localparam int B_X1IE = 3;
    localparam int B_X2IF = 1;
    localparam int B_X1IF = 0;
    // reset_control_register field
    localparam int B_PRIO_EN = 7;
    // Reset values
    localparam logic [DATA_W-1:0] MAIN_RST = 8'h00;
    localparam logic [DATA_W-1:0] SECOND_RST = 8'hF5;
    localparam logic [DATA_W-1:0] THIRD_RST = 8'hE0;
    localparam logic [DATA_W-1:0] RCTL_RST = 8'h00;
    // Vectors
    localparam logic [VEC_W-1:0] VEC_HIGH = 21'h000008;
    localparam logic [VEC_W-1:0] VEC_LOW = 21'h000018;
    // Event status bits
    localparam int EV_W = 3;
    localparam int EV_HIGH = 0;
    localparam int EV_LOW = 1;
    localparam int EV_RET = 2;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } tlic_bus_t;
    typedef struct packed {
        logic load;
        logic high;
        logic [VEC_W-1:0] addr;
    } tlic_vec_t;
    typedef enum logic [1:0] {SVC_NONE, SVC_LOW, SVC_HIGH, SVC_NEST} tlic_svc_t;
endpackage

//--- src/tlic_ctrl.sv
// Purpose: Two-level prioritised interrupt controller for an 8-bit core.
// Assumes: Core takes every vector offered; peripherals give one enabled level.
// Notes: Instruction cycle is a divided enable of sys_clk.
// Functional notes
// - High vector 000008h, low vector 000018h
// - High preempts low; low waits for high
// - Timer, port, pins one and two: flag, enable, priority bit; peripheral: priority bit only
// - Priority mode by reset-control bit 7
// - Priority mode: bit 7 high, bit 6 low
// - Vector when flag, enable, global enable set
// - Compatibility mode: priorities ignored, vector 000008h
// - Compatibility: bit 6 peripherals, bit 7 all
// - Taking clears the governing global enable
// - Core pushes return, loads vector address
// - Return sets the enable cleared on entry
// - Pin events vector in three-four instruction cycles
// - Flags set regardless of any enable
module tlic_ctrl
    import tlic_pkg::*;
#(
    parameter int INSTR_CLKS = INSTR_CLKS_DEF
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire tlic_bus_t bus,
    output logic [DATA_W-1:0] rdata_r,
    input wire logic [2:0] ext_pin,
    input wire logic [3:0] port_pin,
    input wire logic tmr0_overflow,
    input wire logic periph_req,
    input wire logic port_read,
    input wire logic core_return,
    output tlic_vec_t vec_r,
    output logic irq_r,
    output logic pullup_disable_r
);
    logic [DATA_W-1:0] main_r;
    logic [DATA_W-1:0] second_r;
    logic [DATA_W-1:0] third_r;
    logic [DATA_W-1:0] rctl_r;
    logic [EV_W-1:0] stat_r;
    logic [EV_W-1:0] en_r;
    logic [2:0] xs1_r, xs2_r, xs3_r, xstab_r, xprev_r;
    logic [3:0] ps1_r, ps2_r, ps3_r, pstab_r, last_read_r;
    logic [2:0] edge_sel;
    logic [2:0] edge_ev;
    logic mismatch;
    logic [$clog2(INSTR_CLKS+1)-1:0] div_r;
    logic icyc_en;
    logic [5:0] act, prio;
    logic prio_mode;
    logic want_hi, want_lo, want_hi_q, want_lo_q;
    logic armed_hi_r, armed_lo_r;
    logic take_hi, take_lo;
    tlic_svc_t svc_r;
    logic wr_main, wr_second, wr_third, wr_rctl;

    // Write decode
    assign wr_main = bus.wr && bus.addr == OFS_MAIN;
    assign wr_second = bus.wr && bus.addr == OFS_SECOND;
    assign wr_third = bus.wr && bus.addr == OFS_THIRD;
    assign wr_rctl = bus.wr && bus.addr == OFS_RCTL;
    assign prio_mode = rctl_r[B_PRIO_EN];

    // Instruction-cycle enable from a divider
    always_ff @(posedge sys_clk)
    begin
        if (reset || div_r == $bits(div_r)'(INSTR_CLKS - 1))
            div_r <= '0;
        else
            div_r <= div_r + 1'b1;
    end
    assign icyc_en = div_r == $bits(div_r)'(INSTR_CLKS - 1);

    // Pin synchronisers; a level counts once stages two and three agree
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            xs1_r <= '0;
            xs2_r <= '0;
            xs3_r <= '0;
            xstab_r <= '0;
            xprev_r <= '0;
            ps1_r <= '0;
            ps2_r <= '0;
            ps3_r <= '0;
            pstab_r <= '0;
        end
        else
        begin
            xs1_r <= ext_pin;
            xs2_r <= xs1_r;
            xs3_r <= xs2_r;
            xstab_r <= (xs2_r & xs3_r) | (xstab_r & (xs2_r | xs3_r));
            xprev_r <= xstab_r;
            ps1_r <= port_pin;
            ps2_r <= ps1_r;
            ps3_r <= ps2_r;
            pstab_r <= (ps2_r & ps3_r) | (pstab_r & (ps2_r | ps3_r));
        end
    end

    // Edge select per pin: one means rising, zero means falling
    assign edge_sel = {second_r[B_EDG2], second_r[B_EDG1], second_r[B_EDG0]};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_edge
            assign edge_ev[gi] = edge_sel[gi] ? (xstab_r[gi] & ~xprev_r[gi])
                                              : (~xstab_r[gi] & xprev_r[gi]);
        end
    endgenerate

    // Port snapshot taken on every port read; mismatch holds the flag up
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            last_read_r <= '0;
        else if (port_read)
            last_read_r <= pstab_r;
    end
    assign mismatch = pstab_r != last_read_r;

    // Main control: flags set beside software writes, set wins over clear
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            main_r <= MAIN_RST;
        else
        begin
            if (wr_main)
                main_r <= bus.wdata;
            if (tmr0_overflow)
                main_r[B_T0IF] <= 1'b1;
            if (edge_ev[0])
                main_r[B_X0IF] <= 1'b1;
            if (mismatch)
                main_r[B_PCIF] <= 1'b1;
            // Entry clears the level's enable; compatibility uses bit 7 too
            if (take_hi)
                main_r[B_HIGH_LEVEL_GLOBAL_ENABLE] <= 1'b0;
            else if (take_lo)
                main_r[B_LOW_LEVEL_GLOBAL_ENABLE] <= 1'b0;
            else if (core_return && (svc_r == SVC_HIGH || svc_r == SVC_NEST))
                main_r[B_HIGH_LEVEL_GLOBAL_ENABLE] <= 1'b1;
            else if (core_return && svc_r == SVC_LOW)
                main_r[B_LOW_LEVEL_GLOBAL_ENABLE] <= 1'b1;
        end
    end

    // Second control: edge selects, priorities, pull-up control
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            second_r <= SECOND_RST;
        else if (wr_second)
            second_r <= bus.wdata;
    end

    // Third control: pins one and two, peripheral priority
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            third_r <= THIRD_RST;
        else
        begin
            if (wr_third)
                third_r <= bus.wdata;
            if (edge_ev[1])
                third_r[B_X1IF] <= 1'b1;
            if (edge_ev[2])
                third_r[B_X2IF] <= 1'b1;
        end
    end

    // Reset control: priority mode off after reset
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            rctl_r <= RCTL_RST;
        else if (wr_rctl)
            rctl_r <= bus.wdata;
    end

    // Per-source flag and enable (peripheral request alone), with its priority
    assign act = {periph_req,
                  third_r[B_X2IF] & third_r[B_X2IE],
                  third_r[B_X1IF] & third_r[B_X1IE],
                  main_r[B_PCIF] & main_r[B_PCIE],
                  main_r[B_X0IF] & main_r[B_X0IE],
                  main_r[B_T0IF] & main_r[B_T0IE]};
    // Pin zero has no priority bit and is always high
    assign prio = {third_r[B_PRIP], third_r[B_X2IP], third_r[B_X1IP],
                   second_r[B_PCIP], 1'b1, second_r[B_T0IP]};

    // Request decode for the two modes
    always_comb
    begin
        if (prio_mode)
        begin
            want_hi = main_r[B_HIGH_LEVEL_GLOBAL_ENABLE] && |(act & prio);
            want_lo = main_r[B_LOW_LEVEL_GLOBAL_ENABLE] && |(act & ~prio);
        end
        else
        begin
            want_hi = main_r[B_HIGH_LEVEL_GLOBAL_ENABLE] && (|act[4:0] || (main_r[B_LOW_LEVEL_GLOBAL_ENABLE] && act[5]));
            want_lo = 1'b0;
        end
        // A high routine blocks more high; any routine blocks low
        if (svc_r == SVC_HIGH || svc_r == SVC_NEST)
            want_hi = 1'b0;
        if (svc_r != SVC_NONE)
            want_lo = 1'b0;
    end

    // Arm at one instruction boundary, take at the next: bounded pin latency
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            armed_hi_r <= 1'b0;
            armed_lo_r <= 1'b0;
        end
        else if (icyc_en)
        begin
            armed_hi_r <= want_hi && want_hi_q && !take_hi;
            armed_lo_r <= want_lo && want_lo_q && !take_lo;
        end
    end
    assign take_hi = icyc_en && armed_hi_r && want_hi;
    assign take_lo = icyc_en && armed_lo_r && want_lo && !take_hi;
    // One clock of hold before arming keeps pin latency at three to four cycles
    always_ff @(posedge sys_clk)
        {want_hi_q, want_lo_q} <= reset ? 2'h0 : {want_hi, want_lo};

    // Service level tracker
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            svc_r <= SVC_NONE;
        else if (take_hi)
            svc_r <= (svc_r == SVC_LOW) ? SVC_NEST : SVC_HIGH;
        else if (take_lo)
            svc_r <= SVC_LOW;
        else if (core_return)
        begin
            unique case (svc_r)
                SVC_NEST: svc_r <= SVC_LOW;
                SVC_HIGH: svc_r <= SVC_NONE;
                SVC_LOW: svc_r <= SVC_NONE;
                SVC_NONE: svc_r <= SVC_NONE;
            endcase
        end
    end

    // Vector offer to the core: it stacks the return address and jumps
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            vec_r.load <= 1'b0;
            vec_r.high <= 1'b0;
            vec_r.addr <= VEC_HIGH;
        end
        else
        begin
            vec_r.load <= take_hi || take_lo;
            if (take_hi || take_lo)
            begin
                vec_r.high <= take_hi;
                vec_r.addr <= take_hi ? VEC_HIGH : VEC_LOW;
            end
        end
    end

    // Event status, write-only clear, enable and the level interrupt
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            stat_r <= '0;
            en_r <= '0;
            irq_r <= 1'b0;
        end
        else
        begin
            // Clear first, then events: an event in the clear cycle survives
            stat_r <= (stat_r & ~((bus.wr && bus.addr == OFS_CLR) ? bus.wdata[EV_W-1:0] : '0))
                      | {core_return, take_lo, take_hi};
            if (bus.wr && bus.addr == OFS_EN)
                en_r <= bus.wdata[EV_W-1:0];
            irq_r <= |(stat_r & en_r);
        end
    end

    // Pull-up control follows its register bit
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            pullup_disable_r <= SECOND_RST[B_PUD];
        else
            pullup_disable_r <= second_r[B_PUD];
    end

    // Read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            rdata_r <= '0;
        else if (bus.rd)
        begin
            unique case (bus.addr)
                OFS_MAIN: rdata_r <= main_r;
                OFS_SECOND: rdata_r <= {second_r[7:4], 1'b0, second_r[B_T0IP], 1'b0, second_r[B_PCIP]};
                OFS_THIRD: rdata_r <= {third_r[7:3], 1'b0, third_r[1:0]};
                OFS_RCTL: rdata_r <= {rctl_r[B_PRIO_EN], 7'h00};
                OFS_STAT: rdata_r <= {{(DATA_W-EV_W){1'b0}}, stat_r};
                OFS_EN: rdata_r <= {{(DATA_W-EV_W){1'b0}}, en_r};
                default: rdata_r <= '0;
            endcase
        end
        else
            rdata_r <= '0;
    end

    // Checks
    a_vec_high_addr: assert property (@(posedge sys_clk) disable iff (reset)
        vec_r.load && vec_r.high |-> vec_r.addr == VEC_HIGH)
        else $error("high vector address wrong");
    a_vec_low_addr: assert property (@(posedge sys_clk) disable iff (reset)
        vec_r.load && !vec_r.high |-> vec_r.addr == VEC_LOW)
        else $error("low vector address wrong");
    a_low_not_nested: assert property (@(posedge sys_clk) disable iff (reset)
        vec_r.load && !vec_r.high |-> $past(svc_r) == SVC_NONE)
        else $error("low vector taken inside a routine");
    a_compat_single_vec: assert property (@(posedge sys_clk) disable iff (reset)
        vec_r.load && !$past(prio_mode) |-> vec_r.high)
        else $error("low vector in compatibility mode");
    a_take_clears_gie: assert property (@(posedge sys_clk) disable iff (reset)
        vec_r.load && vec_r.high |-> !main_r[B_HIGH_LEVEL_GLOBAL_ENABLE] && $past(main_r[B_HIGH_LEVEL_GLOBAL_ENABLE]))
        else $error("high take left enable set");
    a_low_gated: assert property (@(posedge sys_clk) disable iff (reset)
        vec_r.load && !vec_r.high |-> $past(main_r[B_LOW_LEVEL_GLOBAL_ENABLE]) && !main_r[B_LOW_LEVEL_GLOBAL_ENABLE])
        else $error("low take without low enable");
    a_ret_low_enable: assert property (@(posedge sys_clk) disable iff (reset)
        core_return && svc_r == SVC_LOW && !take_hi |=> main_r[B_LOW_LEVEL_GLOBAL_ENABLE])
        else $error("return did not re-enable low");
    a_timer_flag_set: assert property (@(posedge sys_clk) disable iff (reset)
        tmr0_overflow |=> main_r[B_T0IF])
        else $error("timer flag not set");
    a_pin_flag_set: assert property (@(posedge sys_clk) disable iff (reset)
        edge_ev[0] |=> main_r[B_X0IF])
        else $error("pin flag not set");
    a_port_flag_hold: assert property (@(posedge sys_clk) disable iff (reset)
        mismatch |=> main_r[B_PCIF])
        else $error("port flag dropped during mismatch");
    a_reset_compat: assert property (@(posedge sys_clk)
        $past(reset) |-> !rctl_r[B_PRIO_EN])
        else $error("priority mode set after reset");
    a_take_latency: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(armed_hi_r) && want_hi |-> ##[1:4] vec_r.load || !want_hi)
        else $error("armed request not taken in one instruction cycle");
endmodule

//--- bench/tlic_core_model.sv
// Purpose: Core-side partner that follows vectors and returns from routines.
// Assumes: One load pulse per take; the bench asks for each return.
// Notes: Only nesting depth and the last vector are kept; depth is enough to refuse a stray return.
module tlic_core_model
    import tlic_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire tlic_vec_t vec,
    input wire logic ret_go,
    output logic core_return,
    output logic [VEC_W-1:0] pc_r,
    output logic [2:0] depth_r
);
    timeunit 1ns;
    timeprecision 1ps;
    // Take counts one more nesting level and jumps to the offered vector
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            pc_r <= 21'h000100;
            depth_r <= 3'h0;
        end
        else if (vec.load)
        begin
            pc_r <= vec.addr;
            depth_r <= depth_r + 3'h1;
        end
        else if (core_return)
            depth_r <= depth_r - 3'h1;
    end
    // A return outside any routine would corrupt nesting, so it is dropped
    always_ff @(posedge sys_clk)
    begin
        core_return <= !reset && ret_go && (depth_r != 3'h0);
    end
endmodule

//--- bench/testbench.sv
// Purpose: Self-checking bench for the two-level interrupt controller.
// Assumes: Instruction cycle of 4 clocks; one-cycle register strobes.
// Notes: The serviced flag is cleared before every return, so no recursion is provoked.
module testbench
    import tlic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int IC = 4;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    tlic_bus_t bus = '0;
    logic [DATA_W-1:0] rdata_r;
    logic [2:0] ext_pin = 3'h0;
    logic [3:0] port_pin = 4'h0;
    logic tmr0_overflow = 1'b0;
    logic periph_req = 1'b0;
    logic port_read = 1'b0;
    logic core_return;
    logic ret_go = 1'b0;
    tlic_vec_t vec_r;
    logic irq_r;
    logic pullup_disable_r;
    logic [VEC_W-1:0] pc_r;
    logic [2:0] depth_r;
    int err_count = 0;
    int check_count = 0;
    int n;

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    tlic_ctrl #(.INSTR_CLKS(IC)) u_dut (.sys_clk(sys_clk), .reset(reset), .bus(bus), .rdata_r(rdata_r),
        .ext_pin(ext_pin), .port_pin(port_pin), .tmr0_overflow(tmr0_overflow), .periph_req(periph_req),
        .port_read(port_read), .core_return(core_return), .vec_r(vec_r), .irq_r(irq_r),
        .pullup_disable_r(pullup_disable_r));
    tlic_core_model u_core (.sys_clk(sys_clk), .reset(reset), .vec(vec_r), .ret_go(ret_go),
        .core_return(core_return), .pc_r(pc_r), .depth_r(depth_r));

    task automatic print_verdict();
        if (err_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk_reg(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_vec(input string nm, input logic [VEC_W-1:0] exp, input logic [VEC_W-1:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_bit(input string nm, input logic exp, input logic got);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %b, seen %b", nm, exp, got);
        end
    endtask
    // Register access: one plain write per call, never a memory-to-memory move
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input string nm, input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        @(posedge sys_clk);
        chk_reg(nm, exp, rdata_r);
    endtask
    task automatic wait_load(input int lim, output int cnt);
        cnt = 0;
        while (vec_r.load !== 1'b1 && cnt < lim)
        begin
            @(posedge sys_clk);
            cnt++;
        end
    endtask
    task automatic ret();
        @(posedge sys_clk);
        ret_go <= 1'b1;
        @(posedge sys_clk);
        ret_go <= 1'b0;
    endtask
    task automatic tpulse();
        @(posedge sys_clk);
        tmr0_overflow <= 1'b1;
        @(posedge sys_clk);
        tmr0_overflow <= 1'b0;
    endtask
    task automatic pin0(input logic v);
        @(posedge sys_clk);
        ext_pin[0] <= v;
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        print_verdict();
    end

    initial
    begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        // Reset values, write-only and unmapped places read zero
        rd("main", OFS_MAIN, 8'h00);
        rd("second", OFS_SECOND, 8'hF5);
        rd("third", OFS_THIRD, 8'hE0);
        rd("rctl", OFS_RCTL, 8'h00);
        rd("clear", OFS_CLR, 8'h00);
        rd("unmapped", 4'hF, 8'h00);
        chk_bit("pullup", 1'b1, pullup_disable_r);
        // Flags set with every enable off
        pin0(1'b1);
        repeat (8) @(posedge sys_clk);
        rd("pin flag", OFS_MAIN, 8'h02);
        tpulse();
        repeat (4) @(posedge sys_clk);
        rd("timer flag", OFS_MAIN, 8'h06);
        // Falling select: only the falling edge counts
        wr(OFS_SECOND, 8'hB5);
        wr(OFS_MAIN, 8'h00);
        pin0(1'b0);
        repeat (8) @(posedge sys_clk);
        rd("fall flag", OFS_MAIN, 8'h02);
        wr(OFS_MAIN, 8'h00);
        pin0(1'b1);
        repeat (8) @(posedge sys_clk);
        rd("rise ignored", OFS_MAIN, 8'h00);
        wr(OFS_SECOND, 8'hF5);
        pin0(1'b0);
        // Compatibility take, latency, enable clear, return
        wr(OFS_EN, 8'h01);
        wr(OFS_MAIN, 8'h90);
        pin0(1'b1);
        wait_load(40, n);
        chk_bit("latency", 1'b1, n >= 3 * IC && n <= 4 * IC);
        chk_vec("compat vec", VEC_HIGH, vec_r.addr);
        rd("taken", OFS_MAIN, 8'h12);
        chk_bit("irq on", 1'b1, irq_r);
        wr(OFS_MAIN, 8'h10);
        ret();
        rd("returned", OFS_MAIN, 8'h90);
        rd("status", OFS_STAT, 8'h05);
        wr(OFS_EN, 8'h00);
        // The level output follows the enable one clock after the write lands
        repeat (2) @(posedge sys_clk);
        chk_bit("irq masked", 1'b0, irq_r);
        wr(OFS_EN, 8'h05);
        wr(OFS_CLR, 8'h07);
        rd("status cleared", OFS_STAT, 8'h00);
        chk_bit("irq cleared", 1'b0, irq_r);
        pin0(1'b0);
        // Low-priority timer still goes high in compatibility mode
        wr(OFS_SECOND, 8'hF1);
        wr(OFS_MAIN, 8'hA0);
        tpulse();
        wait_load(40, n);
        chk_bit("prio ignored load", 1'b1, vec_r.load);
        chk_vec("prio ignored", VEC_HIGH, vec_r.addr);
        wr(OFS_MAIN, 8'h20);
        ret();
        // Peripheral request needs both enables
        wr(OFS_MAIN, 8'h80);
        @(posedge sys_clk);
        periph_req <= 1'b1;
        wait_load(20, n);
        chk_bit("periph gated", 1'b0, vec_r.load);
        wr(OFS_MAIN, 8'hC0);
        wait_load(20, n);
        chk_bit("periph load", 1'b1, vec_r.load);
        chk_vec("periph vec", VEC_HIGH, vec_r.addr);
        periph_req <= 1'b0;
        rd("periph taken", OFS_MAIN, 8'h40);
        ret();
        // Priority mode: high taken, low held meanwhile
        wr(OFS_RCTL, 8'h80);
        rd("prio mode", OFS_RCTL, 8'h80);
        wr(OFS_MAIN, 8'hF0);
        pin0(1'b1);
        wait_load(40, n);
        chk_bit("high load", 1'b1, vec_r.load);
        chk_vec("high vec", VEC_HIGH, vec_r.addr);
        chk_bit("high level", 1'b1, vec_r.high);
        ext_pin[0] <= 1'b0;
        rd("high taken", OFS_MAIN, 8'h72);
        tpulse();
        wait_load(30, n);
        chk_bit("low held", 1'b0, vec_r.load);
        wr(OFS_MAIN, 8'h74);
        ret();
        wait_load(40, n);
        chk_bit("low load", 1'b1, vec_r.load);
        chk_vec("low vec", VEC_LOW, vec_r.addr);
        chk_bit("low level", 1'b0, vec_r.high);
        rd("low taken", OFS_MAIN, 8'hB4);
        chk_vec("core pc", VEC_LOW, pc_r);
        // High preempts the low routine
        pin0(1'b1);
        wait_load(40, n);
        chk_bit("preempt load", 1'b1, vec_r.load);
        chk_vec("preempt", VEC_HIGH, vec_r.addr);
        ext_pin[0] <= 1'b0;
        rd("nested", OFS_MAIN, 8'h36);
        chk_reg("core depth", 8'h02, {5'h00, depth_r});
        wr(OFS_MAIN, 8'h30);
        ret();
        ret();
        rd("both back", OFS_MAIN, 8'hF0);
        // Port change flag and its release by a port read
        @(posedge sys_clk);
        port_pin <= 4'h5;
        repeat (8) @(posedge sys_clk);
        rd("port flag", OFS_MAIN, 8'hF1);
        @(posedge sys_clk);
        port_read <= 1'b1;
        @(posedge sys_clk);
        port_read <= 1'b0;
        wr(OFS_MAIN, 8'hF0);
        rd("port clear", OFS_MAIN, 8'hF0);
        // Pins one and two set their flags with their enables off
        @(posedge sys_clk);
        ext_pin[2:1] <= 2'h3;
        repeat (8) @(posedge sys_clk);
        rd("pin flags", OFS_THIRD, 8'hE3);
        print_verdict();
    end
endmodule
